// ---- rtl/tap_pulse_timing.sv ----
`timescale 1ns/10ps
module tap_pulse_timing #(
    parameter int BASE_CYCLES_P = tap_timing_pkg::BASE_CYCLES
) (
    input  wire logic                          i_sys_clk,
    input  wire logic                          i_resetn,
    input  wire logic [7:0]                    i_reg_addr,
    input  wire logic                          i_reg_wr,
    input  wire logic [7:0]                    i_reg_wdata,
    input  wire logic                          i_reg_rd,
    input  wire tap_timing_pkg::pulse_cfg_type i_cfg,
    input  wire logic                          i_double_mode,
    input  wire tap_timing_pkg::sample_type    i_sample,
    output logic [7:0]                         o_reg_rdata,
    output logic                               o_single_pulse,
    output logic                               o_double_pulse,
    output logic                               o_detect_busy
);
    import tap_timing_pkg::*;

    typedef struct packed {
        logic [7:0]            time_limit;
        logic [7:0]            latency;
        logic [7:0]            window;
        logic [7:0]            rdata;
        pulse_cfg_type         cfg_seen;
        logic [BASE_CNT_W-1:0] base_cnt;
        det_state_type         state;
        logic                  second_done;
        logic                  single_evt;
        logic                  double_evt;
    } top_state_type;

    top_state_type st_ff;
    top_state_type nxt_st;

    logic [1:0]         rst_sync_ff;
    logic               rst_n;
    logic               base_tick;
    logic               cfg_change;
    logic               above;
    logic               below;
    logic [SHIFT_W-1:0] tl_shift;
    logic [SHIFT_W-1:0] lat_shift;
    logic               tl_start;
    logic               lat_start;
    logic               win_start;
    logic               tl_stop;
    logic               tl_done;
    logic               lat_done;
    logic               win_done;
    logic               tl_running;
    logic               lat_running;
    logic               win_running;

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    assign tl_shift   = time_limit_shift(i_cfg);
    assign lat_shift  = tl_shift + SH_ONE;
    assign base_tick  = (st_ff.base_cnt == BASE_CNT_W'(BASE_CYCLES_P - 1));
    assign cfg_change = (i_cfg != st_ff.cfg_seen);
    assign above      = i_sample.sample_valid && (i_sample.accel_mag > i_sample.threshold);
    assign below      = i_sample.sample_valid && !(i_sample.accel_mag > i_sample.threshold);

    // timer starts follow the detector transitions
    always_comb begin
        tl_start  = 1'b0;
        lat_start = 1'b0;
        win_start = 1'b0;
        tl_stop   = 1'b0;
        case (st_ff.state)
            S_IDLE: begin
                tl_start = above;
            end
            S_FIRST, S_SECOND: begin
                if (!tl_done && below) begin
                    tl_stop   = 1'b1;
                    lat_start = 1'b1;
                end
            end
            S_LATENCY: begin
                win_start = lat_done && i_double_mode && !st_ff.second_done;
            end
            S_WINDOW: begin
                tl_start = above && !win_done;
            end
            default: begin
                tl_start = 1'b0;
            end
        endcase
    end

    always_comb begin
        nxt_st            = st_ff;
        nxt_st.single_evt = 1'b0;
        nxt_st.double_evt = 1'b0;
        nxt_st.cfg_seen   = i_cfg;
        nxt_st.base_cnt   = (base_tick || cfg_change) ? '0 : st_ff.base_cnt + BASE_CNT_W'(1);
        if (i_reg_wr) begin
            case (i_reg_addr)
                OFF_TIME_LIMIT: nxt_st.time_limit = i_reg_wdata;
                OFF_LATENCY:    nxt_st.latency    = i_reg_wdata;
                OFF_WINDOW:     nxt_st.window     = i_reg_wdata;
                default:        nxt_st.time_limit = st_ff.time_limit;
            endcase
        end
        if (i_reg_rd) begin
            case (i_reg_addr)
                OFF_TIME_LIMIT: nxt_st.rdata = st_ff.time_limit;
                OFF_LATENCY:    nxt_st.rdata = st_ff.latency;
                OFF_WINDOW:     nxt_st.rdata = st_ff.window;
                default:        nxt_st.rdata = RDATA_UNMAPPED;
            endcase
        end
        case (st_ff.state)
            S_IDLE: begin
                if (above) begin
                    nxt_st.state       = S_FIRST;
                    nxt_st.second_done = 1'b0;
                end
            end
            S_FIRST: begin
                if (tl_done) begin
                    nxt_st.state = S_REARM;
                end else if (below) begin
                    nxt_st.state      = S_LATENCY;
                    nxt_st.single_evt = 1'b1;
                end
            end
            S_LATENCY: begin
                if (lat_done) begin
                    nxt_st.state = win_start ? S_WINDOW : S_IDLE;
                end
            end
            S_WINDOW: begin
                if (win_done) begin
                    nxt_st.state = S_IDLE;
                end else if (above) begin
                    nxt_st.state = S_SECOND;
                end
            end
            S_SECOND: begin
                if (tl_done) begin
                    nxt_st.state = S_REARM;
                end else if (below) begin
                    nxt_st.state       = S_LATENCY;
                    nxt_st.second_done = 1'b1;
                    nxt_st.double_evt  = 1'b1;
                end
            end
            S_REARM: begin
                if (below) begin
                    nxt_st.state = S_IDLE;
                end
            end
            default: begin
                nxt_st.state = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff            <= '0;
            st_ff.time_limit <= RST_TIME_LIMIT;
            st_ff.latency    <= RST_LATENCY;
            st_ff.window     <= RST_WINDOW;
            st_ff.state      <= S_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // pulse time limit, counted in limit steps
    interval_timer u_limit_timer (
        .i_sys_clk      (i_sys_clk),
        .i_rst_n        (rst_n),
        .i_start        (tl_start),
        .i_stop         (tl_stop),
        .i_restart_step (cfg_change),
        .i_base_tick    (base_tick),
        .i_shift        (tl_shift),
        .i_limit        (st_ff.time_limit),
        .o_running      (tl_running),
        .o_done         (tl_done)
    );

    // latency and window share the doubled step
    interval_timer u_latency_timer (
        .i_sys_clk      (i_sys_clk),
        .i_rst_n        (rst_n),
        .i_start        (lat_start),
        .i_stop         (1'b0),
        .i_restart_step (cfg_change),
        .i_base_tick    (base_tick),
        .i_shift        (lat_shift),
        .i_limit        (st_ff.latency),
        .o_running      (lat_running),
        .o_done         (lat_done)
    );

    interval_timer u_window_timer (
        .i_sys_clk      (i_sys_clk),
        .i_rst_n        (rst_n),
        .i_start        (win_start),
        .i_stop         (tl_start),
        .i_restart_step (cfg_change),
        .i_base_tick    (base_tick),
        .i_shift        (lat_shift),
        .i_limit        (st_ff.window),
        .o_running      (win_running),
        .o_done         (win_done)
    );

    assign o_reg_rdata    = st_ff.rdata;
    assign o_single_pulse = st_ff.single_evt;
    assign o_double_pulse = st_ff.double_evt;
    assign o_detect_busy  = (st_ff.state != S_IDLE);

    a_first_needs_fall: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        o_single_pulse |-> $past(st_ff.state) == S_FIRST && $past(below) && !$past(tl_done))
        else $error("single pulse reported without a timely fall");

    a_tl_write_lands: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        i_reg_wr && i_reg_addr == OFF_TIME_LIMIT |=> st_ff.time_limit == $past(i_reg_wdata))
        else $error("time-limit write did not land");

    a_on_normal_fast: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        i_cfg.pulse_filter_enable && i_cfg.mode == MODE_NORMAL
            && i_cfg.output_data_rate == ODR_800HZ |-> tl_shift == SH_ONE)
        else $error("wrong filtered step at fastest rate");

    a_off_lp_slow: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        !i_cfg.pulse_filter_enable && i_cfg.mode == MODE_LOW_POWER
            && i_cfg.output_data_rate >= ODR_12HZ5 |-> tl_shift == SH_OFF_LP_SLOW)
        else $error("wrong unfiltered low-power step at slow rate");

    a_latency_holds: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        st_ff.state == S_LATENCY && !lat_done |=> st_ff.state == S_LATENCY && lat_running
            && !o_single_pulse && !o_double_pulse)
        else $error("pulse accepted during latency");

    a_latency_hires_step: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        !i_cfg.pulse_filter_enable && i_cfg.mode == MODE_HIGH_RES |-> lat_shift == SH_ONE)
        else $error("wrong unfiltered high-resolution latency step");

    a_threshold_start: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        st_ff.state == S_IDLE && above |=> st_ff.state == S_FIRST && tl_running)
        else $error("threshold crossing did not start the limit interval");

    a_window_expiry: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        st_ff.state == S_WINDOW && win_done |=> st_ff.state == S_IDLE && !win_running)
        else $error("second pulse accepted after the window");

    a_cfg_restart: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        cfg_change |=> st_ff.base_cnt == '0)
        else $error("time base not restarted on configuration change");

endmodule

// ---- inc/tap_timing_pkg.sv ----
package tap_timing_pkg;

    // register map
    localparam logic [7:0] OFF_TIME_LIMIT = 8'h26;
    localparam logic [7:0] OFF_LATENCY    = 8'h27;
    localparam logic [7:0] OFF_WINDOW     = 8'h28;
    localparam logic [7:0] RST_TIME_LIMIT = 8'h00;
    localparam logic [7:0] RST_LATENCY    = 8'h00;
    localparam logic [7:0] RST_WINDOW     = 8'h00;
    localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

    // time base: smallest step, 0.625 ms, at the 40 ns clock
    localparam int TIME_BASE_NS  = 625000;
    localparam int CLK_PERIOD_NS = 40;
    localparam int BASE_CYCLES   = (TIME_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BASE_CNT_W    = 24;

    // step prescaler: step = base << shift, shift at most 9
    localparam int SHIFT_W    = 4;
    localparam int PRESCALE_W = 10;

    // data rate codes
    localparam logic [2:0] ODR_800HZ  = 3'h0;
    localparam logic [2:0] ODR_400HZ  = 3'h1;
    localparam logic [2:0] ODR_50HZ   = 3'h4;
    localparam logic [2:0] ODR_12HZ5  = 3'h5;

    // step shifts in units of the time base
    localparam logic [SHIFT_W-1:0] SH_ONE          = 4'h1;
    localparam logic [SHIFT_W-1:0] SH_ZERO         = 4'h0;
    localparam logic [SHIFT_W-1:0] SH_ON_NORMAL    = 4'h5;
    localparam logic [SHIFT_W-1:0] SH_ON_LOW_NOISE = 4'h7;
    localparam logic [SHIFT_W-1:0] SH_ON_HIRES_800 = 4'h1;
    localparam logic [SHIFT_W-1:0] SH_ON_HIRES     = 4'h2;
    localparam logic [SHIFT_W-1:0] SH_ON_LP_12HZ5  = 4'h7;
    localparam logic [SHIFT_W-1:0] SH_ON_LP_SLOW   = 4'h8;
    localparam logic [SHIFT_W-1:0] SH_OFF_NORMAL   = 4'h3;
    localparam logic [SHIFT_W-1:0] SH_OFF_LOW_NOISE = 4'h5;
    localparam logic [SHIFT_W-1:0] SH_OFF_LP_SLOW  = 4'h6;

    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_LOW_NOISE,
        MODE_HIGH_RES,
        MODE_LOW_POWER
    } mode_type;

    typedef struct packed {
        logic [2:0] output_data_rate;
        mode_type   mode;
        logic       pulse_filter_enable;
    } pulse_cfg_type;

    typedef struct packed {
        logic       sample_valid;
        logic [6:0] accel_mag;
        logic [6:0] threshold;
    } sample_type;

    typedef enum logic [2:0] {
        S_IDLE,
        S_FIRST,
        S_LATENCY,
        S_WINDOW,
        S_SECOND,
        S_REARM
    } det_state_type;

    // time-limit step as a power of two of the time base
    function automatic logic [SHIFT_W-1:0] time_limit_shift(input pulse_cfg_type cfg);
        logic [2:0]         r;
        logic               slow;
        logic [SHIFT_W-1:0] up;
        logic [SHIFT_W-1:0] sh;
        r    = cfg.output_data_rate;
        slow = (r > ODR_50HZ);
        up   = {1'b0, r};
        sh   = SH_ZERO;
        if (cfg.pulse_filter_enable) begin
            case (cfg.mode)
                MODE_NORMAL:    sh = slow ? SH_ON_NORMAL : up + SH_ONE;
                MODE_LOW_NOISE: sh = slow ? SH_ON_LOW_NOISE : up + SH_ONE;
                MODE_HIGH_RES:  sh = (r == ODR_800HZ) ? SH_ON_HIRES_800 : SH_ON_HIRES;
                default:        sh = (r == ODR_12HZ5) ? SH_ON_LP_12HZ5 :
                                     slow ? SH_ON_LP_SLOW : up + SH_ONE;
            endcase
        end else begin
            case (cfg.mode)
                MODE_NORMAL:    sh = slow ? SH_OFF_NORMAL :
                                     (r <= ODR_400HZ) ? SH_ZERO : up - SH_ONE;
                MODE_LOW_NOISE: sh = slow ? SH_OFF_LOW_NOISE :
                                     (r <= ODR_400HZ) ? SH_ZERO : up - SH_ONE;
                MODE_HIGH_RES:  sh = SH_ZERO;
                default:        sh = slow ? SH_OFF_LP_SLOW : up;
            endcase
        end
        return sh;
    endfunction

endpackage

// ---- rtl/interval_timer.sv ----
`timescale 1ns/10ps
module interval_timer (
    input  wire logic                                   i_sys_clk,
    input  wire logic                                   i_rst_n,
    input  wire logic                                   i_start,
    input  wire logic                                   i_stop,
    input  wire logic                                   i_restart_step,
    input  wire logic                                   i_base_tick,
    input  wire logic [tap_timing_pkg::SHIFT_W-1:0]     i_shift,
    input  wire logic [7:0]                             i_limit,
    output logic                                        o_running,
    output logic                                        o_done
);
    import tap_timing_pkg::*;

    typedef struct packed {
        logic                  running;
        logic [PRESCALE_W-1:0] prescale;
        logic [7:0]            steps;
    } timer_state_type;

    timer_state_type st_ff;
    timer_state_type nxt_st;
    logic [PRESCALE_W-1:0] step_mask;

    assign step_mask = (PRESCALE_W'(1) << i_shift) - PRESCALE_W'(1);
    assign o_running = st_ff.running;
    assign o_done    = st_ff.running && (st_ff.steps == i_limit);

    always_comb begin
        nxt_st = st_ff;
        if (i_start) begin
            nxt_st.running  = 1'b1;
            nxt_st.prescale = '0;
            nxt_st.steps    = '0;
        end else if (i_stop || o_done) begin
            nxt_st.running = 1'b0;
        end else if (st_ff.running) begin
            if (i_restart_step) begin
                nxt_st.prescale = '0;
            end else if (i_base_tick) begin
                if (st_ff.prescale >= step_mask) begin
                    nxt_st.prescale = '0;
                    nxt_st.steps    = st_ff.steps + 8'h01;
                end else begin
                    nxt_st.prescale = st_ff.prescale + PRESCALE_W'(1);
                end
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    a_done_stops: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        o_done && !i_start |=> !o_running)
        else $error("timer kept running after reaching its limit");

endmodule

// ---- verification/tap_host_model.sv ----
`timescale 1ns/10ps
module tap_host_model
    import tap_timing_pkg::*;
(
    input  wire logic       i_sys_clk,
    input  wire logic [7:0] i_reg_rdata,
    output logic [7:0]      o_reg_addr,
    output logic            o_reg_wr,
    output logic [7:0]      o_reg_wdata,
    output logic            o_reg_rd
);
    // idle bus parks on an address that no register owns
    initial begin
        o_reg_addr  = 8'hFF;
        o_reg_wr    = 1'b0;
        o_reg_wdata = 8'h00;
        o_reg_rd    = 1'b0;
    end

    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(negedge i_sys_clk);
        o_reg_addr  = addr;
        o_reg_wdata = data;
        o_reg_wr    = 1'b1;
        @(negedge i_sys_clk);
        o_reg_wr    = 1'b0;
        // released data no longer shows the written value
        o_reg_wdata = ~data;
        o_reg_addr  = 8'hFF;
    endtask

    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(negedge i_sys_clk);
        o_reg_addr = addr;
        o_reg_rd   = 1'b1;
        @(negedge i_sys_clk);
        o_reg_rd   = 1'b0;
        o_reg_addr = 8'hFF;
        data       = i_reg_rdata;
    endtask

    // latency is always written, for single and double use alike
    task automatic program_timing(input logic [7:0] limit, input logic [7:0] latency,
                                  input logic [7:0] window);
        write_reg(OFF_TIME_LIMIT, limit);
        write_reg(OFF_LATENCY, latency);
        write_reg(OFF_WINDOW, window);
    endtask
endmodule

// ---- verification/tap_pulse_timing_tb.sv ----
`timescale 1ns/10ps
module tap_pulse_timing_tb;
    import tap_timing_pkg::*;
    localparam int         BASE_P = 4;
    localparam int         NCFG   = 8;
    localparam logic [6:0] THR    = 7'h20;
    logic          i_sys_clk;
    logic          i_resetn;
    logic [7:0]    i_reg_addr;
    logic          i_reg_wr;
    logic [7:0]    i_reg_wdata;
    logic          i_reg_rd;
    pulse_cfg_type i_cfg;
    logic          i_double_mode;
    sample_type    i_sample;
    logic [7:0]    o_reg_rdata;
    logic          o_single_pulse;
    logic          o_double_pulse;
    logic          o_detect_busy;
    logic [7:0]    rd_val;
    logic [15:0]   n_single;
    logic [15:0]   n_double;
    logic [15:0]   ns;
    logic [15:0]   nd;
    int            s;
    int            fail_count = 0;
    int            n_compared = 0;
    // limit step per row in units of the 4-cycle (BASE_P) time base; latency and window steps are twice that
    logic [2:0]    odr_t   [NCFG] = '{3'h0, 3'h5, 3'h2, 3'h6, 3'h1, 3'h5, 3'h4, 3'h4};
    mode_type      mode_t  [NCFG] = '{MODE_NORMAL, MODE_LOW_NOISE, MODE_HIGH_RES, MODE_LOW_POWER,
                                      MODE_NORMAL, MODE_LOW_NOISE, MODE_HIGH_RES, MODE_LOW_POWER};
    logic          filt_t  [NCFG] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
    int            units_t [NCFG] = '{2, 128, 4, 256, 1, 32, 1, 16};

    tap_pulse_timing #(.BASE_CYCLES_P(BASE_P)) u_tap_pulse_timing (
        .i_sys_clk      (i_sys_clk),
        .i_resetn       (i_resetn),
        .i_reg_addr     (i_reg_addr),
        .i_reg_wr       (i_reg_wr),
        .i_reg_wdata    (i_reg_wdata),
        .i_reg_rd       (i_reg_rd),
        .i_cfg          (i_cfg),
        .i_double_mode  (i_double_mode),
        .i_sample       (i_sample),
        .o_reg_rdata    (o_reg_rdata),
        .o_single_pulse (o_single_pulse),
        .o_double_pulse (o_double_pulse),
        .o_detect_busy  (o_detect_busy)
    );

    tap_host_model u_tap_host_model (
        .i_sys_clk   (i_sys_clk),
        .i_reg_rdata (o_reg_rdata),
        .o_reg_addr  (i_reg_addr),
        .o_reg_wr    (i_reg_wr),
        .o_reg_wdata (i_reg_wdata),
        .o_reg_rd    (i_reg_rd)
    );

    initial i_sys_clk = 1'b0;
    always #20 i_sys_clk = ~i_sys_clk;

    // event tallies
    always @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            n_single <= 16'h0000;
            n_double <= 16'h0000;
        end else begin
            n_single <= n_single + {15'h0000, o_single_pulse};
            n_double <= n_double + {15'h0000, o_double_pulse};
        end
    end

    task automatic end_of_test();
        if (fail_count == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic compare_reg(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic compare_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic compare_count(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(negedge i_sys_clk);
    endtask

    // above-threshold run of dur samples; equal to threshold counts as below
    task automatic tap(input int dur);
        @(negedge i_sys_clk);
        i_sample.accel_mag = THR + 7'h01;
        wait_cyc(dur);
        i_sample.accel_mag = THR;
    endtask

    initial begin
        repeat (90000) @(posedge i_sys_clk);
        fail_count++;
        end_of_test();
    end

    initial begin
        i_resetn      = 1'b0;
        i_cfg         = '{ODR_800HZ, MODE_NORMAL, 1'b0};
        i_double_mode = 1'b0;
        i_sample      = '{1'b1, THR, THR};
        wait_cyc(4);
        i_resetn = 1'b1;
        wait_cyc(3);
        u_tap_host_model.write_reg(8'h29, 8'h5A);
        for (int a = 0; a < 3; a++) begin
            u_tap_host_model.read_reg(OFF_TIME_LIMIT + 8'(a), rd_val);
            compare_reg(rd_val, 8'h00);
        end
        u_tap_host_model.read_reg(8'h29, rd_val);
        compare_reg(rd_val, RDATA_UNMAPPED);
        u_tap_host_model.program_timing(8'h06, 8'h04, 8'h03);
        u_tap_host_model.read_reg(OFF_TIME_LIMIT, rd_val);
        compare_reg(rd_val, 8'h06);
        u_tap_host_model.read_reg(OFF_LATENCY, rd_val);
        compare_reg(rd_val, 8'h04);
        u_tap_host_model.read_reg(OFF_WINDOW, rd_val);
        compare_reg(rd_val, 8'h03);
        // limit 6 steps, latency 4 double steps, per step-size row
        for (int k = 0; k < NCFG; k++) begin
            s = BASE_P * units_t[k];
            @(negedge i_sys_clk);
            i_cfg = '{odr_t[k], mode_t[k], filt_t[k]};
            wait_cyc(4);
            ns = n_single;
            tap(4 * s);
            tap(s);
            wait_cyc(3 * s);
            compare_count(n_single, ns + 16'h0001);
            compare_bit(o_detect_busy, 1'b1);
            wait_cyc(4 * s);
            compare_bit(o_detect_busy, 1'b0);
            tap(7 * s);
            wait_cyc(3);
            compare_count(n_single, ns + 16'h0001);
            compare_bit(o_detect_busy, 1'b0);
        end
        // double mode at the 4-cycle step row
        @(negedge i_sys_clk);
        i_cfg         = '{odr_t[4], mode_t[4], filt_t[4]};
        i_double_mode = 1'b1;
        s             = BASE_P * units_t[4];
        wait_cyc(4);
        ns = n_single;
        nd = n_double;
        tap(2 * s);
        wait_cyc(9 * s);
        tap(2 * s);
        wait_cyc(20 * s);
        compare_count(n_double, nd + 16'h0001);
        compare_count(n_single, ns + 16'h0001);
        tap(2 * s);
        wait_cyc(16 * s);
        tap(2 * s);
        wait_cyc(20 * s);
        compare_count(n_double, nd + 16'h0001);
        compare_count(n_single, ns + 16'h0003);
        end_of_test();
    end
endmodule
